// *** design/snhc_pkg.sv ***
package snhc_pkg;

    // =====================================================================
    // host operation codes
    typedef enum logic [2:0]
    {
        SNHC_OP_CMD   = 3'b000,
        SNHC_OP_ADDR  = 3'b001,
        SNHC_OP_WRITE = 3'b010,
        SNHC_OP_READ  = 3'b011,
        SNHC_OP_WAIT  = 3'b100
    } snhc_op_t;

    // =====================================================================
    // pin timing
    localparam int SNHC_CLK_MHZ        = 100;
    localparam int SNHC_STROBE_LOW_NS  = 30;
    localparam int SNHC_STROBE_HIGH_NS = 20;
    localparam int SNHC_SETUP_NS       = 10;
    localparam int SNHC_RECOVERY_US    = 10;
    localparam int SNHC_STROBE_LOW_CYC  = (SNHC_STROBE_LOW_NS * SNHC_CLK_MHZ + 999) / 1000;
    localparam int SNHC_STROBE_HIGH_CYC = (SNHC_STROBE_HIGH_NS * SNHC_CLK_MHZ + 999) / 1000;
    localparam int SNHC_SETUP_CYC       = (SNHC_SETUP_NS * SNHC_CLK_MHZ + 999) / 1000;
    localparam int SNHC_RECOVERY_CYC    = SNHC_RECOVERY_US * SNHC_CLK_MHZ;
    localparam int SNHC_CNT_W           = 16;

    // =====================================================================
    // array organisation and addressing
    localparam int SNHC_PAGES_PER_BLOCK = 32;
    localparam int SNHC_HALF_PAGE_BYTES = 256;
    localparam int SNHC_SPARE_BYTES     = 16;
    localparam int SNHC_MAIN_WORDS      = 256;
    localparam int SNHC_SPARE_WORDS     = 8;
    localparam int SNHC_ADDR_CYCLES     = 4;
    localparam int SNHC_MIN_BLOCKS_512M = 4016;
    localparam int SNHC_MIN_BLOCKS_1G   = 8032;
    localparam int SNHC_BYTE_W          = 8;
    localparam int SNHC_WORD_W          = 16;

endpackage : snhc_pkg

// *** design/snhc_stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface snhc_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : snhc_stream_if

`default_nettype wire

// *** design/snhc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module snhc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    snhc_stream_if.snk in_s,
    snhc_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } snhc_fifo_st_t;

    snhc_fifo_st_t          s_q;
    snhc_fifo_st_t          s_d;
    logic [WIDTH-1:0]       mem [DEPTH];
    logic                   push;
    logic                   pop;

    assign in_s.ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_s.valid = (s_q.cnt != '0);
    assign out_s.data  = mem[s_q.rd];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop)
        begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // storage holds no reset: only valid entries are ever read
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[s_q.wr] <= in_s.data;
        end
    end
endmodule : snhc_fifo

`default_nettype wire

// *** design/snhc_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module snhc_host
    import snhc_pkg::*;
#(
    parameter int BUS_W         = SNHC_WORD_W,
    parameter int FIFO_DEPTH    = 16,
    parameter int RECOVERY_CYC  = SNHC_RECOVERY_CYC,
    parameter bit KEEP_SELECT_ON_READ = 1'b1
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             op_valid,
    output logic                  op_ready,
    input  wire snhc_op_t         op_code,
    input  wire logic [BUS_W-1:0] op_data,
    input  wire logic             write_enable_prog,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [BUS_W-1:0]      rd_data,
    output logic                  ready_state,
    output logic                  chip_sel_n,
    output logic                  command_strobe,
    output logic                  address_latch_strobe,
    output logic                  write_n,
    output logic                  read_n,
    output logic                  write_protect_n,
    output logic [BUS_W-1:0]      io_out,
    output logic [BUS_W-1:0]      io_oe,
    input  wire logic [BUS_W-1:0] io_in,
    input  wire logic             busy_n_open_drain
);
    // =====================================================================
    // state
    typedef enum logic [2:0]
    {
        SNHC_S_RECOVER = 3'b000,
        SNHC_S_IDLE    = 3'b001,
        SNHC_S_SETUP   = 3'b010,
        SNHC_S_LOW     = 3'b011,
        SNHC_S_HIGH    = 3'b100,
        SNHC_S_WAIT    = 3'b101
    } snhc_state_t;

    typedef struct packed {
        snhc_state_t       st;
        snhc_op_t          op;
        logic [SNHC_CNT_W-1:0] cnt;
        logic [BUS_W-1:0]  dout;
        logic [2:0]        bsync;
        logic              busy_seen;
        logic              ce_n;
        logic              cle;
        logic              ale;
        logic              we_n;
        logic              re_n;
        logic              wp_n;
        logic [BUS_W-1:0]  oe;
        logic              op_rdy;
        logic              rdy_state;
        logic              cap_valid;
        logic [BUS_W-1:0]  cap_data;
    } snhc_host_st_t;

    snhc_host_st_t s_q;
    snhc_host_st_t s_d;

    snhc_stream_if #(.W(BUS_W)) cap_s ();
    snhc_stream_if #(.W(BUS_W)) out_s ();

    assign cap_s.valid = s_q.cap_valid;
    assign cap_s.data  = s_q.cap_data;

    snhc_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .in_s    (cap_s),
        .out_s   (out_s)
    );

    // output register stage for the read stream
    logic             rv_q;
    logic [BUS_W-1:0] rdat_q;
    assign out_s.ready = !rv_q || rd_ready;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rv_q   <= 1'b0;
            rdat_q <= '0;
        end
        else if (out_s.ready)
        begin
            rv_q   <= out_s.valid;
            rdat_q <= out_s.data;
        end
    end

    // =====================================================================
    // helpers
    function automatic logic [BUS_W-1:0] snhc_lane_oe(input snhc_op_t op);
        // commands and addresses only drive the low byte lanes
        if (op == SNHC_OP_WRITE)
        begin
            snhc_lane_oe = '1;
        end
        else
        begin
            snhc_lane_oe = BUS_W'({SNHC_BYTE_W{1'b1}});
        end
    endfunction : snhc_lane_oe

    logic busy_now;
    // a change counts once stages two and three agree
    assign busy_now = (s_q.bsync[2:1] == 2'b00) ? 1'b1 :
                      (s_q.bsync[2:1] == 2'b11) ? 1'b0 : s_q.busy_seen;

    always_comb
    begin
        s_d           = s_q;
        s_d.bsync     = {s_q.bsync[1:0], busy_n_open_drain};
        s_d.busy_seen = busy_now;
        s_d.cap_valid = 1'b0;
        if (s_q.cap_valid && !cap_s.ready)
        begin
            s_d.cap_valid = 1'b1;
        end
        case (s_q.st)
            SNHC_S_RECOVER:
            begin
                // strobe and protect quiet while the device recovers
                s_d.we_n = 1'b1;
                s_d.wp_n = 1'b0;
                if (s_q.cnt == SNHC_CNT_W'(RECOVERY_CYC - 1))
                begin
                    s_d.cnt = '0;
                    s_d.st  = SNHC_S_WAIT;
                    s_d.op  = SNHC_OP_WAIT;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            SNHC_S_IDLE:
            begin
                s_d.wp_n = write_enable_prog;
                if (op_valid && s_q.op_rdy)
                begin
                    s_d.op_rdy = 1'b0;
                    s_d.op     = op_code;
                    s_d.cnt    = '0;
                    s_d.ce_n   = 1'b0;
                    s_d.cle    = (op_code == SNHC_OP_CMD);
                    s_d.ale    = (op_code == SNHC_OP_ADDR);
                    s_d.dout   = op_data;
                    s_d.oe     = (op_code == SNHC_OP_READ || op_code == SNHC_OP_WAIT) ? '0 :
                                 snhc_lane_oe(op_code);
                    s_d.st     = (op_code == SNHC_OP_WAIT) ? SNHC_S_WAIT : SNHC_S_SETUP;
                end
            end
            SNHC_S_SETUP:
            begin
                if (s_q.cnt == SNHC_CNT_W'(SNHC_SETUP_CYC - 1))
                begin
                    s_d.cnt = '0;
                    s_d.st  = SNHC_S_LOW;
                    if (s_q.op == SNHC_OP_READ)
                    begin
                        s_d.re_n = 1'b0;
                    end
                    else
                    begin
                        s_d.we_n = 1'b0;
                    end
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            SNHC_S_LOW:
            begin
                if (s_q.cnt == SNHC_CNT_W'(SNHC_STROBE_LOW_CYC - 1))
                begin
                    s_d.cnt  = '0;
                    s_d.st   = SNHC_S_HIGH;
                    s_d.we_n = 1'b1;
                    s_d.re_n = 1'b1;
                    if (s_q.op == SNHC_OP_READ)
                    begin
                        // one word per read pulse, sampled as read_n returns high
                        s_d.cap_valid = 1'b1;
                        s_d.cap_data  = io_in;
                    end
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            SNHC_S_HIGH:
            begin
                if (s_q.cnt == SNHC_CNT_W'(SNHC_STROBE_HIGH_CYC - 1))
                begin
                    s_d.cnt    = '0;
                    s_d.cle    = 1'b0;
                    s_d.ale    = 1'b0;
                    s_d.oe     = '0;
                    s_d.st     = SNHC_S_IDLE;
                    s_d.op_rdy = cap_s.ready;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            SNHC_S_WAIT:
            begin
                // select may drop during read busy only if the device allows it
                s_d.ce_n = KEEP_SELECT_ON_READ ? 1'b0 : 1'b1;
                if (s_q.cnt != SNHC_CNT_W'(SNHC_STROBE_HIGH_CYC + 3))
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                else if (!busy_now)
                begin
                    s_d.cnt       = '0;
                    s_d.rdy_state = 1'b1;
                    s_d.st        = SNHC_S_IDLE;
                    s_d.op_rdy    = 1'b1;
                end
            end
            default:
            begin
                s_d.st = SNHC_S_IDLE;
            end
        endcase
        // a shared line can be pulled low by any device at any time, so track it
        s_d.rdy_state = (s_q.st == SNHC_S_RECOVER) ? 1'b0 : !busy_now;
        if (s_d.op_rdy && !cap_s.ready)
        begin
            s_d.op_rdy = 1'b0;
        end
        else if (s_q.st == SNHC_S_IDLE && !s_q.op_rdy && cap_s.ready)
        begin
            s_d.op_rdy = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q      <= '0;
            s_q.st   <= SNHC_S_RECOVER;
            s_q.op   <= SNHC_OP_WAIT;
            s_q.bsync <= 3'b000;
            s_q.busy_seen <= 1'b1;
            s_q.ce_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.re_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // outputs
    assign op_ready             = s_q.op_rdy;
    assign ready_state          = s_q.rdy_state;
    assign chip_sel_n           = s_q.ce_n;
    assign command_strobe       = s_q.cle;
    assign address_latch_strobe = s_q.ale;
    assign write_n              = s_q.we_n;
    assign read_n               = s_q.re_n;
    assign write_protect_n      = s_q.wp_n;
    assign io_out               = s_q.dout;
    assign io_oe                = s_q.oe;
    assign rd_valid             = rv_q;
    assign rd_data              = rdat_q;
endmodule : snhc_host

`default_nettype wire

// *** testbench/snhc_host_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pin protocol checks on the host ports
module snhc_host_monitor #(
    parameter int BUS_W = 16
) (
    input wire logic             mclk,
    input wire logic             sys_rst,
    input wire logic             op_ready,
    input wire logic             ready_state,
    input wire logic             chip_sel_n,
    input wire logic             command_strobe,
    input wire logic             address_latch_strobe,
    input wire logic             write_n,
    input wire logic             read_n,
    input wire logic             write_protect_n,
    input wire logic [BUS_W-1:0] io_oe,
    input wire logic             busy_n_open_drain
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_cmd_lvl;
        command_strobe && !write_n |-> !chip_sel_n && !address_latch_strobe && read_n;
    endproperty
    a_cmd_lvl: assert property (p_cmd_lvl) else $error("command cycle with wrong strobe levels");
    property p_adr_lvl;
        address_latch_strobe && !write_n |-> !chip_sel_n && !command_strobe && read_n;
    endproperty
    a_adr_lvl: assert property (p_adr_lvl) else $error("address cycle with wrong strobe levels");
    property p_hi_free;
        (command_strobe || address_latch_strobe) |-> io_oe[BUS_W-1:8] == '0;
    endproperty
    a_hi_free: assert property (p_hi_free) else $error("upper byte driven in command or address");
    property p_we_width;
        $fell(write_n) |-> !write_n [*3] ##1 write_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe pulse width wrong");
    property p_rd_lvl;
        !read_n |-> !chip_sel_n && write_n && !command_strobe && !address_latch_strobe && io_oe == '0;
    endproperty
    a_rd_lvl: assert property (p_rd_lvl) else $error("read strobe with wrong pin levels");
    property p_rd_width;
        $fell(read_n) |-> !read_n [*3] ##1 read_n;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe pulse width wrong");
    property p_recovery;
        $fell(sys_rst) |-> (write_n && !op_ready && !write_protect_n) [*8];
    endproperty
    a_recovery: assert property (p_recovery) else $error("pins not quiet in recovery");
    property p_cs_hold;
        !busy_n_open_drain && !chip_sel_n |=> !chip_sel_n;
    endproperty
    a_cs_hold: assert property (p_cs_hold) else $error("select released while device busy");
    property p_busy_seen;
        !busy_n_open_drain [*6] |=> !ready_state;
    endproperty
    a_busy_seen: assert property (p_busy_seen) else $error("ready reported on a low busy line");
endmodule : snhc_host_monitor
`default_nettype wire

// *** testbench/snhc_nand_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// behavioural x16 device, 16-word window of one page
module snhc_nand_model #(
    parameter int BUSY_NS = 300
) (
    input wire logic        chip_sel_n,
    input wire logic        command_strobe,
    input wire logic        address_latch_strobe,
    input wire logic        write_n,
    input wire logic        read_n,
    input wire logic        write_protect_n,
    input wire logic [15:0] bus,
    output logic [15:0]     dev_q,
    output logic            dev_oe,
    output logic            busy_n
);
    logic [15:0] mem  [16]; // slice of one x16 page only
    logic [15:0] pend [16];
    logic [7:0]  cmd;
    logic [3:0]  col;
    int          na;

    // pulse holds the strobe process, so nothing is latched while busy
    task automatic pulse;
        begin
            busy_n = 1'b0;
            #BUSY_NS busy_n = 1'b1;
        end
    endtask : pulse

    initial
    begin
        busy_n = 1'b0;
        dev_q = 16'h0000;
        cmd = 8'h00;
        col = 4'h0;
        na = 0;
        foreach (mem[i])
        begin
            mem[i] = 16'hFFFF;
            pend[i] = 16'hFFFF;
        end
        #150 busy_n = 1'b1;
    end

    assign dev_oe = !chip_sel_n && !read_n;

    always @(posedge write_n)
        if (!chip_sel_n && busy_n)
        begin
            if (command_strobe)
            begin
                cmd = bus[7:0];
                na = 0;
                if (cmd == 8'h80)
                    pend = mem;
                if (cmd == 8'h10 && write_protect_n)
                begin
                    mem = pend;
                    pulse();
                end
            end
            else if (address_latch_strobe)
            begin
                if (na == 0)
                    col = bus[3:0];
                na++;
                if (na == 4 && cmd == 8'h00)
                    pulse();
            end
            else
            begin
                pend[col] = bus;
                col++;
            end
        end

    always @(negedge read_n)
        if (!chip_sel_n && busy_n)
        begin
            dev_q = mem[col];
            col++;
        end
endmodule : snhc_nand_model
`default_nettype wire

// *** testbench/snhc_host_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module snhc_host_bench
    import snhc_pkg::*;
;
    logic        mclk, sys_rst, op_valid, write_enable_prog, rd_ready, ok;
    snhc_op_t    op_code;
    logic [15:0] op_data, rd_data, io_out, io_oe, dev_q, bus;
    logic        op_ready, rd_valid, ready_state, chip_sel_n, command_strobe;
    logic        address_latch_strobe, write_n, read_n, write_protect_n, dev_oe, busy_n;
    int          err_count, check_count, lim;

    snhc_host #(.BUS_W(16), .FIFO_DEPTH(16), .RECOVERY_CYC(8), .KEEP_SELECT_ON_READ(1'b1)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_data(op_data), .write_enable_prog(write_enable_prog), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .ready_state(ready_state), .chip_sel_n(chip_sel_n), .command_strobe(command_strobe),
        .address_latch_strobe(address_latch_strobe), .write_n(write_n), .read_n(read_n),
        .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe), .io_in(bus),
        .busy_n_open_drain(busy_n));
    snhc_nand_model u_mem (
        .chip_sel_n(chip_sel_n), .command_strobe(command_strobe), .address_latch_strobe(address_latch_strobe),
        .write_n(write_n), .read_n(read_n), .write_protect_n(write_protect_n), .bus(bus), .dev_q(dev_q),
        .dev_oe(dev_oe), .busy_n(busy_n));

    // undriven lines show the inverse of the last word, not a stale copy
    assign bus = (io_out & io_oe) | (~io_oe & (dev_oe ? dev_q : ~dev_q));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================
    // shared tasks
    task automatic test_done;
        begin
            $display("checks=%0d mismatches=%0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask : test_done

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        begin
            check_count++;
            if (seen !== exp)
            begin
                err_count++;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask : check

    task automatic tmo;
        begin
            check(16'h0000, 16'h0001);
            test_done();
        end
    endtask : tmo

    task automatic wait_idle;
        int n;
        begin
            n = 0;
            while (op_ready !== 1'b1 && n < 3000)
            begin
                @(negedge mclk);
                n++;
            end
            if (n >= 3000)
                tmo();
        end
    endtask : wait_idle

    task automatic op(input snhc_op_t c, input logic [15:0] d);
        int n;
        begin
            n = 0;
            op_valid = 1'b1;
            op_code = c;
            op_data = d;
            while (op_ready !== 1'b1 && n < lim)
            begin
                @(negedge mclk);
                n++;
            end
            ok = (n < lim);
            @(negedge mclk);
            op_valid = 1'b0;
            @(negedge mclk);
            if (!ok && lim > 100)
                tmo();
        end
    endtask : op

    task automatic rd(input logic [15:0] exp);
        int n;
        begin
            n = 0;
            while (rd_valid !== 1'b1 && n < 200)
            begin
                @(negedge mclk);
                n++;
            end
            if (n >= 200)
                tmo();
            check(rd_data, exp);
            @(negedge mclk);
        end
    endtask : rd

    task automatic seq(input logic [7:0] c);
        begin
            op(SNHC_OP_CMD, {8'h00, c});
            repeat (4) op(SNHC_OP_ADDR, 16'h0000);
        end
    endtask : seq

    // ==========================================
    // scenarios
    task automatic t_prog(input logic wp, input logic [15:0] a, input logic [15:0] b);
        begin
            write_enable_prog = wp;
            seq(8'h80);
            op(SNHC_OP_WRITE, a);
            op(SNHC_OP_WRITE, b);
            op(SNHC_OP_CMD, 16'h0010);
            op(SNHC_OP_WAIT, 16'h0000);
            write_enable_prog = 1'b0;
            $display("program done, protect released=%0d", wp);
        end
    endtask : t_prog

    task automatic t_read(input logic [15:0] a, input logic [15:0] b);
        begin
            seq(8'h00);
            op(SNHC_OP_WAIT, 16'h0000);
            wait_idle();
            check(ready_state, 16'h0001);
            op(SNHC_OP_READ, 16'h0000);
            rd(a);
            op(SNHC_OP_READ, 16'h0000);
            rd(b);
            $display("read back done");
        end
    endtask : t_read

    task automatic t_fill;
        int k;
        begin
            seq(8'h00);
            op(SNHC_OP_WAIT, 16'h0000);
            rd_ready = 1'b0;
            lim = 60;
            k = 0;
            ok = 1'b1;
            while (ok && k < 20)
            begin
                op(SNHC_OP_READ, 16'h0000);
                if (ok)
                    k++;
            end
            lim = 2000;
            // fifo depth plus the output stage; the model's column wraps after sixteen
            check(k[15:0], 16'h0011);
            rd_ready = 1'b1;
            for (int i = 0; i < 17; i++)
                rd(i[3:0] == 4'h0 ? 16'hA55A : (i == 1 ? 16'h3CC3 : 16'hFFFF));
            repeat (20) @(negedge mclk);
            check(rd_valid, 16'h0000);
            $display("buffer fill and drain done");
        end
    endtask : t_fill

    task automatic t_reset;
        begin
            sys_rst = 1'b1;
            @(negedge mclk);
            sys_rst = 1'b0;
            @(negedge mclk);
            check(op_ready, 16'h0000);
            check(write_n, 16'h0001);
            check(write_protect_n, 16'h0000);
            wait_idle();
            t_read(16'hA55A, 16'h3CC3);
            $display("mid-run reset done");
        end
    endtask : t_reset

    initial
    begin
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_code = SNHC_OP_CMD;
        op_data = 16'h0000;
        write_enable_prog = 1'b0;
        rd_ready = 1'b1;
        err_count = 0;
        check_count = 0;
        lim = 2000;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        t_prog(1'b1, 16'hA55A, 16'h3CC3);
        t_read(16'hA55A, 16'h3CC3);
        t_prog(1'b0, 16'h1234, 16'h5678);
        t_read(16'hA55A, 16'h3CC3);
        t_fill();
        t_reset();
        test_done();
    end
endmodule : snhc_host_bench

bind snhc_host snhc_host_monitor #(.BUS_W(BUS_W)) u_mon (
    .mclk(mclk), .sys_rst(sys_rst), .op_ready(op_ready), .ready_state(ready_state), .chip_sel_n(chip_sel_n),
    .command_strobe(command_strobe), .address_latch_strobe(address_latch_strobe), .write_n(write_n),
    .read_n(read_n), .write_protect_n(write_protect_n), .io_oe(io_oe), .busy_n_open_drain(busy_n_open_drain));
`default_nettype wire
